// file: core/dta_defs.vh
`ifndef DTA_DEFS_VH
`define DTA_DEFS_VH
`define DTA_CH_WRITE      3'h0
`define DTA_CH_READ       3'h1
`define DTA_MAX_BURST_B   8'h80
`define DTA_MAX_BURST_W   5'h10
`define DTA_FMT_MWR       8'h60
`define DTA_FMT_MRD       8'h20
`define DTA_FMT_CPLD      8'h4a
`define DTA_HDR_CREDITS   8'h01
`define DTA_DATA_CR_BYTES 8'h10
`define DTA_RX_DEPTH      5'h10
`define DTA_TAG_BASE      8'h00
`endif

// file: core/dta_adapter.v
// Notes on behaviour
// - Channel 0 carries only outgoing writes from the bus master to the link.
// - Channel 1 carries only reads that fetch data from the link side.
// - Every other channel number is ignored and gets no response.
// - A channel 0 write burst becomes one memory write packet in the queue.
// - A queued write needs posted credits, then a send request, then data.
// - The first channel 1 read of a transfer is ended with a retry; later reads take data.
// - Each retried read becomes a memory read packet in the same queue.
// - A queued read leaves the queue only with enough non-posted credits.
// - The send request is raised before any packet word is driven.
// - Read data may arrive in several completions and is gathered in full.
// - Data ready on channel 1 is raised only once all data is buffered.
// - Completion credits are returned as buffered data is drained.
// - A completion whose tag is not the outstanding tag is dropped.
// - The send request is withheld while reported credits fall short.
// - Packet words move only after the core answers the request with ready.
`timescale 1ns/1ps
`include "dta_defs.vh"
module dta_adapter (
    input  wire        CLOCK_I,
    input  wire        RST_N_I,
    input  wire        WB_CYC_I,
    input  wire        WB_STB_I,
    input  wire        WB_WE_I,
    input  wire [2:0]  WB_CH_I,
    input  wire [31:0] WB_ADR_I,
    input  wire [63:0] WB_DAT_I,
    input  wire [7:0]  WB_LEN_I,
    output wire        WB_ACK_O,
    output wire        WB_RTY_O,
    output reg  [63:0] WB_DAT_O,
    output wire        DMA_REQ_O,
    input  wire        DMA_ACK_I,
    output wire        TX_REQ_O,
    input  wire        TX_RDY_I,
    output reg  [63:0] TX_DATA_O,
    output reg         TX_ST_O,
    output reg         TX_END_O,
    input  wire [7:0]  TX_CA_PH_I,
    input  wire [11:0] TX_CA_PD_I,
    input  wire [7:0]  TX_CA_NPH_I,
    input  wire        RX_ST_I,
    input  wire        RX_END_I,
    input  wire        RX_VAL_I,
    input  wire [63:0] RX_DATA_I,
    output reg         CPL_CR_O,
    output reg  [7:0]  CPL_CR_NUM_O
);
    localparam S_IDLE = 4'h1;
    localparam S_REQ  = 4'h2;
    localparam S_HDR  = 4'h4;
    localparam S_DATA = 4'h8;

    // Payload store for one write burst, 16 words of 8 bytes.
    reg  [63:0] wbuf [0:15];
    reg  [4:0]  wcnt_reg;
    reg  [31:0] waddr_reg;
    reg  [7:0]  wlen_reg;
    // Two-entry packet queue: kind (1 = write), address, length in bytes.
    reg         q_kind [0:1];
    reg  [31:0] q_addr [0:1];
    reg  [7:0]  q_len  [0:1];
    reg  [1:0]  q_cnt_reg;
    reg         q_wp_reg;
    reg         q_rp_reg;
    reg  [3:0]  st_reg;
    reg  [4:0]  tx_idx_reg;
    reg         rd_busy_reg;
    reg  [7:0]  rd_need_reg;
    reg  [7:0]  rd_got_reg;
    reg  [7:0]  tag_reg;
    reg         rx_keep_reg;
    reg  [63:0] rbuf [0:15];
    reg  [4:0]  rwp_reg;
    reg  [4:0]  rrp_reg;
    reg         rdy_reg;

    wire wb_req   = WB_CYC_I & WB_STB_I;
    wire wr_beat  = wb_req & WB_WE_I & (WB_CH_I == `DTA_CH_WRITE);
    wire rd_ch    = wb_req & ~WB_WE_I & (WB_CH_I == `DTA_CH_READ);
    // Other channels fall through both terms and are never answered.
    wire rd_first = rd_ch & ~rd_busy_reg;
    wire rd_drain = rd_ch & rdy_reg & (rrp_reg != rwp_reg);
    wire q_full   = (q_cnt_reg == 2'h2);
    // The write buffer is single, so a burst waits while one is queued.
    wire w_hold   = q_full | (q_cnt_reg != 2'h0 & q_kind[q_rp_reg])
                  | (st_reg != S_IDLE);
    wire w_take   = wr_beat & ~w_hold;
    wire w_last   = w_take & (wcnt_reg + 5'h01 ==
                    ((WB_LEN_I + 8'h07) >> 3));
    wire r_push   = rd_first & ~q_full;
    wire [7:0] dwords = q_len[q_rp_reg] >> 2;
    wire [7:0] data_cr = (q_len[q_rp_reg] + `DTA_DATA_CR_BYTES - 8'h01)
                       >> 4;
    wire cr_ok = q_kind[q_rp_reg] ?
                 (TX_CA_PH_I >= `DTA_HDR_CREDITS &&
                  TX_CA_PD_I >= {4'h0, data_cr}) :
                 (TX_CA_NPH_I >= `DTA_HDR_CREDITS);
    wire q_pop    = (st_reg == S_DATA) & TX_END_O;
    wire [4:0] rrp_inc = rrp_reg + 5'h01;
    // Payload words of a kept completion pass a two-entry buffer first.
    wire        cbuf_in_valid = RX_VAL_I & ~RX_ST_I & rx_keep_reg;
    wire        cbuf_valid;
    wire        cbuf_ready    = (rwp_reg != `DTA_RX_DEPTH);
    wire [63:0] cbuf_data;

    assign WB_ACK_O  = w_take | rd_drain;
    assign WB_RTY_O  = r_push;
    assign DMA_REQ_O = rdy_reg;
    assign TX_REQ_O  = (st_reg == S_REQ);

    // The core cannot be stalled, so the input ready is not used; a full
    // store leaves two words in the buffer and later words are dropped.
    dta_pair_buf #(
        .WIDTH       (64)
    ) cbuf_u (
        .clk_i       (CLOCK_I),
        .rst_n_i     (RST_N_I),
        .in_valid_i  (cbuf_in_valid),
        .in_ready_o  (),
        .in_data_i   (RX_DATA_I),
        .out_valid_o (cbuf_valid),
        .out_ready_i (cbuf_ready),
        .out_data_o  (cbuf_data)
    );

    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wcnt_reg  <= 5'h00;
            waddr_reg <= 32'h0;
            wlen_reg  <= 8'h00;
            q_cnt_reg <= 2'h0;
            q_wp_reg  <= 1'b0;
            q_rp_reg  <= 1'b0;
        end else begin
            if (w_take) begin
                wbuf[wcnt_reg[3:0]] <= WB_DAT_I;
                if (wcnt_reg == 5'h00) begin
                    waddr_reg <= WB_ADR_I;
                    wlen_reg  <= WB_LEN_I;
                end
                wcnt_reg <= w_last ? 5'h00 : wcnt_reg + 5'h01;
            end
            if (w_last) begin
                q_kind[q_wp_reg] <= 1'b1;
                q_addr[q_wp_reg] <= (wcnt_reg == 5'h00) ? WB_ADR_I
                                                         : waddr_reg;
                q_len[q_wp_reg]  <= (wcnt_reg == 5'h00) ? WB_LEN_I
                                                         : wlen_reg;
                q_wp_reg         <= ~q_wp_reg;
            end else if (r_push) begin
                q_kind[q_wp_reg] <= 1'b0;
                q_addr[q_wp_reg] <= WB_ADR_I;
                q_len[q_wp_reg]  <= WB_LEN_I;
                q_wp_reg         <= ~q_wp_reg;
            end
            if (q_pop)
                q_rp_reg <= ~q_rp_reg;
            q_cnt_reg <= q_cnt_reg + {1'b0, (w_last | r_push)}
                       - {1'b0, q_pop};
        end
    end

    // Send sequence: credits, request, wait ready, header, payload.
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_reg     <= S_IDLE;
            tx_idx_reg <= 5'h00;
            TX_DATA_O  <= 64'h0;
            TX_ST_O    <= 1'b0;
            TX_END_O   <= 1'b0;
            tag_reg    <= `DTA_TAG_BASE;
        end else begin
            TX_ST_O  <= 1'b0;
            TX_END_O <= 1'b0;
            case (st_reg)
            S_IDLE: begin
                if (q_cnt_reg != 2'h0 && cr_ok)
                    st_reg <= S_REQ;
            end
            S_REQ: begin
                if (TX_RDY_I) begin
                    st_reg    <= S_HDR;
                    TX_ST_O   <= 1'b1;
                    TX_DATA_O <= {q_kind[q_rp_reg] ? `DTA_FMT_MWR
                                                   : `DTA_FMT_MRD,
                                  8'h00, 8'h00, dwords,
                                  8'h00, tag_reg, 8'h0f, 8'hff};
                    tx_idx_reg <= 5'h00;
                end
            end
            S_HDR: begin
                st_reg    <= S_DATA;
                TX_DATA_O <= {q_addr[q_rp_reg], 32'h0};
                TX_END_O  <= ~q_kind[q_rp_reg];
            end
            S_DATA: begin
                if (TX_END_O) begin
                    st_reg <= S_IDLE;
                    if (!q_kind[q_rp_reg])
                        tag_reg <= tag_reg + 8'h01;
                end else begin
                    TX_DATA_O  <= wbuf[tx_idx_reg[3:0]];
                    tx_idx_reg <= tx_idx_reg + 5'h01;
                    TX_END_O   <= (tx_idx_reg + 5'h01 ==
                                   {2'b00, dwords[7:1]});
                end
            end
            default: st_reg <= S_IDLE;
            endcase
        end
    end

    // Completion intake: header word holds the tag, the rest is payload.
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rd_busy_reg  <= 1'b0;
            rd_need_reg  <= 8'h00;
            rd_got_reg   <= 8'h00;
            rx_keep_reg  <= 1'b0;
            rwp_reg      <= 5'h00;
            rrp_reg      <= 5'h00;
            rdy_reg      <= 1'b0;
            WB_DAT_O     <= 64'h0;
            CPL_CR_O     <= 1'b0;
            CPL_CR_NUM_O <= 8'h00;
        end else begin
            CPL_CR_O <= 1'b0;
            if (r_push) begin
                rd_busy_reg <= 1'b1;
                rd_need_reg <= WB_LEN_I;
                rd_got_reg  <= 8'h00;
                rwp_reg     <= 5'h00;
                rrp_reg     <= 5'h00;
            end
            if (RX_VAL_I && RX_ST_I) begin
                rx_keep_reg <= rd_busy_reg & ~rdy_reg &
                    (RX_DATA_I[63:56] == `DTA_FMT_CPLD) &
                    (RX_DATA_I[23:16] == tag_reg - 8'h01);
            end
            if (cbuf_valid && cbuf_ready) begin
                rbuf[rwp_reg[3:0]] <= cbuf_data;
                rwp_reg    <= rwp_reg + 5'h01;
                rd_got_reg <= rd_got_reg + 8'h08;
            end
            if (RX_VAL_I && RX_END_I)
                rx_keep_reg <= 1'b0;
            if (rd_busy_reg && !rdy_reg && rd_need_reg != 8'h00 &&
                rd_got_reg >= rd_need_reg)
                rdy_reg <= 1'b1;
            // Look one word ahead on a drain so back-to-back reads see
            // fresh data, and preload the first word before data ready.
            if (rrp_reg != rwp_reg)
                WB_DAT_O <= rbuf[rd_drain ? rrp_inc[3:0] : rrp_reg[3:0]];
            if (rd_drain) begin
                rrp_reg      <= rrp_reg + 5'h01;
                CPL_CR_O     <= 1'b1;
                CPL_CR_NUM_O <= 8'h08;
                if (rrp_reg + 5'h01 == rwp_reg) begin
                    rdy_reg     <= 1'b0;
                    rd_busy_reg <= 1'b0;
                end
            end
            if (DMA_ACK_I && rdy_reg && !rd_drain)
                rdy_reg <= 1'b1;
        end
    end
endmodule // dta_adapter

// Two-entry buffer: the sink may stall without the source losing a word,
// traded against one cycle of latency.
module dta_pair_buf #(
    parameter WIDTH = 64
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg  [WIDTH-1:0] slot_reg [0:1];
    reg  [1:0]       cnt_reg;
    reg              rp_reg;
    reg              wp_reg;

    wire push = in_valid_i & (cnt_reg != 2'h2);
    wire pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (cnt_reg != 2'h2);
    assign out_valid_o = (cnt_reg != 2'h0);
    assign out_data_o  = slot_reg[rp_reg];

    always @(posedge clk_i) begin
        if (push)
            slot_reg[wp_reg] <= in_data_i;
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 2'h0;
            rp_reg  <= 1'b0;
            wp_reg  <= 1'b0;
        end else begin
            if (push)
                wp_reg <= ~wp_reg;
            if (pop)
                rp_reg <= ~rp_reg;
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // dta_pair_buf

// file: verification/dta_checker.sv
`timescale 1ns/1ps
module dta_checker (
    input wire       CLOCK_I,
    input wire       RST_N_I,
    input wire       WB_CYC_I,
    input wire       WB_STB_I,
    input wire       WB_WE_I,
    input wire [2:0] WB_CH_I,
    input wire       WB_ACK_O,
    input wire       WB_RTY_O,
    input wire       DMA_REQ_O,
    input wire       TX_REQ_O,
    input wire       TX_RDY_I,
    input wire       TX_ST_O,
    input wire       TX_END_O,
    input wire [7:0] TX_CA_PH_I,
    input wire [7:0] TX_CA_NPH_I,
    input wire       RX_END_I,
    input wire       CPL_CR_O,
    input wire [7:0] CPL_CR_NUM_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    wire sel = WB_CYC_I && WB_STB_I;
    reg  go_reg;
    // A packet may only start once its request has been granted.
    always @(posedge CLOCK_I or negedge RST_N_I)
        if (!RST_N_I) go_reg <= 1'b0;
        else if (TX_REQ_O && TX_RDY_I) go_reg <= 1'b1;
        else if (TX_END_O) go_reg <= 1'b0;
    property p_rty; WB_RTY_O |-> sel && !WB_WE_I && WB_CH_I == 3'h1; endproperty
    a_rty: assert property (p_rty) else $error("bad retry");
    property p_ign; sel && WB_CH_I > 3'h1 |-> !WB_ACK_O && !WB_RTY_O; endproperty
    a_ign: assert property (p_ign) else $error("answered");
    property p_wr; WB_ACK_O && WB_WE_I |-> WB_CH_I == 3'h0; endproperty
    a_wr: assert property (p_wr) else $error("write off ch0");
    property p_hold; TX_REQ_O && !TX_RDY_I |=> TX_REQ_O; endproperty
    a_hold: assert property (p_hold) else $error("req dropped");
    property p_st; TX_ST_O |-> go_reg; endproperty
    a_st: assert property (p_st) else $error("word before grant");
    property p_cr; $rose(TX_REQ_O) |-> $past(TX_CA_PH_I) != 8'h00 ||
        $past(TX_CA_NPH_I) != 8'h00; endproperty
    a_cr: assert property (p_cr) else $error("req without credit");
    property p_dr; $rose(DMA_REQ_O) |-> $past(RX_END_I) ||
        $past(RX_END_I, 2) || $past(RX_END_I, 3); endproperty
    a_dr: assert property (p_dr) else $error("early data ready");
    property p_rel; WB_ACK_O && !WB_WE_I |=> CPL_CR_O &&
        CPL_CR_NUM_O == 8'h08; endproperty
    a_rel: assert property (p_rel) else $error("no credit back");
endmodule // dta_checker
bind dta_adapter dta_checker chk_u (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_CH_I(WB_CH_I), .WB_ACK_O(WB_ACK_O), .WB_RTY_O(WB_RTY_O),
    .DMA_REQ_O(DMA_REQ_O), .TX_REQ_O(TX_REQ_O), .TX_RDY_I(TX_RDY_I),
    .TX_ST_O(TX_ST_O), .TX_END_O(TX_END_O), .TX_CA_PH_I(TX_CA_PH_I),
    .TX_CA_NPH_I(TX_CA_NPH_I), .RX_END_I(RX_END_I), .CPL_CR_O(CPL_CR_O),
    .CPL_CR_NUM_O(CPL_CR_NUM_O));

// file: verification/dta_core_model.sv
`timescale 1ns/1ps
module dta_core_model (
    input  wire        clk_i,
    input  wire        tx_req_i,
    input  wire        tx_st_i,
    input  wire        tx_end_i,
    input  wire [63:0] tx_data_i,
    input  wire        slow_i,
    output reg         tx_rdy_o = 1'b0,
    output reg         rx_st_o = 1'b0,
    output reg         rx_end_o = 1'b0,
    output reg         rx_val_o = 1'b0,
    output reg  [63:0] rx_data_o = 64'h5a5a_0f0f_a5a5_f0f0
);
    reg [63:0] pkt [0:17];
    reg        in_reg = 1'b0;
    integer    nw = 0, npk = 0, dly = 0;
    // Ready is held to the last word, so a slow grant still frames a packet.
    always @(posedge clk_i) begin
        dly <= tx_req_i ? dly + 1 : 0;
        if (tx_req_i && dly >= (slow_i ? 4 : 0)) tx_rdy_o <= 1'b1;
        if (tx_end_i) tx_rdy_o <= 1'b0;
        if (tx_end_i) npk <= npk + 1;
        if (tx_st_i || in_reg) pkt[tx_st_i ? 0 : nw] <= tx_data_i;
        if (tx_st_i || in_reg) nw <= tx_st_i ? 1 : nw + 1;
        in_reg <= (tx_st_i || in_reg) && !tx_end_i;
    end
    task send(input [63:0] hdr, input [63:0] s, input integer n);
        integer i;
        begin
            @(negedge clk_i);
            {rx_st_o, rx_val_o, rx_data_o} = {2'b11, hdr};
            for (i = 0; i < n; i = i + 1) begin
                @(negedge clk_i);
                {rx_st_o, rx_end_o, rx_data_o} = {1'b0, i == n - 1, s + i};
            end
            @(negedge clk_i);
            {rx_end_o, rx_val_o, rx_data_o} = {2'b00, ~rx_data_o};
        end
    endtask
endmodule // dta_core_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
`include "dta_defs.vh"
module tb_top;
    reg         clk, rst_n, cyc, stb, we, dack, slow, hit, rty_s;
    reg  [2:0]  ch;
    reg  [7:0]  len, ph, nph;
    reg  [11:0] pd;
    reg  [31:0] adr, seed;
    reg  [63:0] wd, got, s, hdr;
    reg  [63:0] exp_w [0:15];
    wire        ack, rty, dreq, treq, trdy, tst, tend, rxs, rend, rval, cr;
    wire [7:0]  crn;
    wire [63:0] rd, td, rxd;
    integer     err_total = 0, comparisons = 0, pk = 0, i, k;
    dta_adapter dut_u (.CLOCK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_CH_I(ch), .WB_ADR_I(adr),
        .WB_DAT_I(wd), .WB_LEN_I(len), .WB_ACK_O(ack), .WB_RTY_O(rty),
        .WB_DAT_O(rd), .DMA_REQ_O(dreq), .DMA_ACK_I(dack), .TX_REQ_O(treq),
        .TX_RDY_I(trdy), .TX_DATA_O(td), .TX_ST_O(tst), .TX_END_O(tend),
        .TX_CA_PH_I(ph), .TX_CA_PD_I(pd), .TX_CA_NPH_I(nph), .RX_ST_I(rxs),
        .RX_END_I(rend), .RX_VAL_I(rval), .RX_DATA_I(rxd), .CPL_CR_O(cr),
        .CPL_CR_NUM_O(crn));
    dta_core_model core_u (.clk_i(clk), .tx_req_i(treq), .tx_st_i(tst),
        .tx_end_i(tend), .tx_data_i(td), .slow_i(slow), .tx_rdy_o(trdy),
        .rx_st_o(rxs), .rx_end_o(rend), .rx_val_o(rval), .rx_data_o(rxd));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task results;
        begin
            $display("compares %0d errors %0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task cmp(input [63:0] g, input [63:0] e);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    // Beat: hold the request until answered or the bound runs out.
    task beat(input w, input [2:0] c, input [63:0] d, input integer lim,
        input e);
        integer n;
        begin
            @(negedge clk);
            {cyc, stb, we, ch, wd, hit} = {2'b11, w, c, d, 1'b0};
            for (n = 0; n < lim && !hit; n = n + 1) begin
                #2;
                {hit, rty_s, got} = {ack | rty, rty, rd};
                @(posedge clk);
            end
            if (e) cmp(hit, 1'b1);
            if (e && hit !== 1'b1) results;
        end
    endtask
    task idle;
        begin
            @(negedge clk);
            {cyc, stb} = 2'b00;
        end
    endtask
    task wpk;
        begin
            pk = pk + 1;
            for (k = 0; k < 300 && core_u.npk < pk; k = k + 1) @(negedge clk);
            cmp(core_u.npk, pk);
            if (core_u.npk != pk) results;
        end
    endtask
    task wr(input [7:0] l);
        begin
            len = l;
            seed = lfsr(seed);
            adr = {seed[31:3], 3'h0};
            for (i = 0; i < l / 8; i = i + 1) begin
                seed = lfsr(seed);
                exp_w[i] = {seed, ~seed};
                beat(1'b1, 3'h0, exp_w[i], 40, 1'b1);
            end
            idle;
            if (ph == 8'h00) begin
                repeat (20) @(negedge clk);
                cmp(treq, 1'b0);
                ph = 8'h10;
            end
            wpk;
            cmp(core_u.nw, l / 8 + 2);
            cmp(core_u.pkt[1][63:32], adr);
            for (i = 0; i < l / 8; i = i + 1)
                cmp(core_u.pkt[i + 2], exp_w[i]);
        end
    endtask
    initial begin
        {rst_n, cyc, stb, we, dack, slow, ch, len, adr, wd} = 0;
        {ph, pd, nph, seed} = {8'h10, 12'h040, 8'h10, 32'h227c};
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        for (k = 2; k < 8; k = k + 1) begin
            beat(k[0], k[2:0], 64'h0, 4, 1'b0);
            cmp(hit, 1'b0);
        end
        idle;
        ph = 8'h00;
        wr(8'h80);
        wr(8'h08);
        for (pk = pk; pk < 8; pk = pk) begin
            seed = lfsr(seed);
            slow = seed[0];
            wr({seed[4:1], 3'h0} + 8'h08);
        end
        {nph, len} = 16'h0020;
        beat(1'b0, 3'h1, 64'h0, 4, 1'b1);
        cmp(rty_s, 1'b1);
        idle;
        repeat (20) @(negedge clk);
        cmp(treq, 1'b0);
        nph = 8'h10;
        wpk;
        cmp(core_u.nw, 2);
        hdr = {`DTA_FMT_CPLD, core_u.pkt[0][55:0]};
        s = {lfsr(seed), seed};
        core_u.send(hdr ^ 64'hff_0000, s, 2);
        repeat (6) @(negedge clk);
        cmp(dreq, 1'b0);
        core_u.send(hdr, s, 2);
        repeat (6) @(negedge clk);
        cmp(dreq, 1'b0);
        core_u.send(hdr, s + 2, 2);
        repeat (4) @(negedge clk);
        cmp(dreq, 1'b1);
        if (dreq !== 1'b1) results;
        dack = 1'b1;
        for (k = 0; k < 4; k = k + 1) begin
            beat(1'b0, 3'h1, 64'h0, 10, 1'b1);
            #1;
            cmp(got, s + k);
            cmp({cr, crn}, 9'h108);
        end
        idle;
        dack = 1'b0;
        repeat (4) @(negedge clk);
        cmp(dreq, 1'b0);
        results;
    end
endmodule // tb_top
